// ==== rtl/spi_rtc_calendar_core.sv ====
// real-time clock and calendar core with serial register access
`timescale 1ns/1ps
`include "rtc_map.svh"
module spi_rtc_calendar_core (
    input  wire logic  i_clock,
    input  wire logic  i_rst_b,
    input  wire logic  i_spi_clock,
    input  wire logic  i_chip_enable_b,
    input  wire logic  i_serial_in_pin,
    input  wire logic  i_crystal_input,
    input  wire logic  i_power_fail,
    output logic       o_crystal_output,
    output logic       o_serial_out_pin,
    output logic       o_serial_out_oe,
    output logic       o_square_wave_pin,
    output logic       o_shared_interrupt_test_pin,
    output logic       o_shared_interrupt_test_oe,
    output logic       o_reset_pin,
    output logic       o_reset_oe,
    output logic       o_battery_select
);
    import rtc_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [8:0] bcd_inc(
        input logic [7:0] v,
        input logic [7:0] top,
        input logic [7:0] low
    );
        if (v >= top) begin
            bcd_inc = {1'b1, low};
        end else if (v[3:0] >= 4'h9) begin
            bcd_inc = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_inc = {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
        end
    endfunction

    // year in bcd divisible by four
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4)
                   || (y[3:0] == 4'h8);
        end
    endfunction

    function automatic logic [7:0] month_len(
        input logic [7:0] mon,
        input logic [7:0] yr
    );
        case (mon)
            8'h02:   month_len = is_leap(yr) ? 8'h29 : 8'h28;
            8'h04,
            8'h06,
            8'h09,
            8'h11:   month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [1:0] xtal_sync_q;
    logic       xtal_prev_q;
    logic [1:0] pf_sync_q;
    logic [1:0] frz_sync_q;
    logic [1:0] wr_sync_q;
    logic       wr_seen_q;
    logic       link_freeze;
    logic       link_toggle;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            xtal_sync_q <= 2'h0;
            xtal_prev_q <= 1'b0;
            pf_sync_q   <= 2'h0;
            frz_sync_q  <= 2'h0;
            wr_sync_q   <= 2'h0;
            wr_seen_q   <= 1'b0;
        end else begin
            xtal_sync_q <= {xtal_sync_q[0], i_crystal_input};
            xtal_prev_q <= xtal_sync_q[1];
            pf_sync_q   <= {pf_sync_q[0], i_power_fail};
            frz_sync_q  <= {frz_sync_q[0], link_freeze};
            wr_sync_q   <= {wr_sync_q[0], link_toggle};
            wr_seen_q   <= wr_sync_q[1];
        end
    end

    wire osc_tick   = xtal_sync_q[1] && !xtal_prev_q;
    wire power_low  = pf_sync_q[1];
    wire freeze_w   = frz_sync_q[1];
    wire wr_event   = wr_sync_q[1] ^ wr_seen_q;

    // ----------------------------------------
    // power sequencing
    // ----------------------------------------
    pwr_state_t state_q;
    pwr_state_t state_d;
    logic [11:0] rec_q;

    wire rec_done = (rec_q == 12'(`RTC_REC_CYCLES - 1));

    always_comb begin
        case (state_q)
            PS_RESET:   state_d = PS_RECOVER;
            PS_RECOVER: begin
                if (power_low) begin
                    state_d = PS_BACKUP;
                end else if (rec_done) begin
                    state_d = PS_RUN;
                end else begin
                    state_d = PS_RECOVER;
                end
            end
            PS_RUN:     state_d = power_low ? PS_BACKUP : PS_RUN;
            PS_BACKUP:  state_d = power_low ? PS_BACKUP : PS_RECOVER;
            default:    state_d = PS_RESET;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_q <= PS_RESET;
            rec_q   <= 12'h000;
        end else begin
            state_q <= state_d;
            rec_q   <= (state_q == PS_RECOVER) ? 12'(rec_q + 12'h001) : 12'h000;
        end
    end

    // ----------------------------------------
    // serial link and write capture
    // ----------------------------------------
    wr_word_t    link_word;
    logic [5:0]  link_ptr;
    logic [7:0]  rd_byte;
    logic [7:0]  mem_q [0:31];

    spi_link u_link (
        .i_spi_clock      (i_spi_clock),
        .i_rst_b          (i_rst_b),
        .i_chip_enable_b  (i_chip_enable_b),
        .i_serial_in_pin  (i_serial_in_pin),
        .i_read_byte      (rd_byte),
        .o_pointer        (link_ptr),
        .o_freeze         (link_freeze),
        .o_wr_word        (link_word),
        .o_wr_toggle      (link_toggle),
        .o_serial_out_pin (o_serial_out_pin),
        .o_serial_out_oe  (o_serial_out_oe)
    );

    // the word is held steady for a whole byte time after its toggle
    wire        wr_accept = wr_event && (state_q == PS_RUN)
                         && !power_low;
    wire [4:0]  wr_addr   = link_word.addr[4:0];
    wire [7:0]  wr_data   = link_word.data;
    wire        wr_clock  = wr_accept && ({1'b0, wr_addr} < `RTC_CLOCK_BYTES);
    wire        wr_map    = wr_accept && !wr_clock;

    // pointer is quasi-static when the link samples this
    assign rd_byte = mem_q[link_ptr[4:0]];

    // ----------------------------------------
    // oscillator division
    // ----------------------------------------
    logic [15:0] acc_q;
    logic [14:0] div_q;

    wire [15:0] acc_sum   = acc_q + `RTC_HUND_STEP;
    wire        hund_tick = osc_tick && (acc_sum >= `RTC_HUND_WRAP);

    // exact hundredths: 100 steps per 32768 oscillator periods
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            acc_q <= 16'h0000;
            div_q <= 15'h0000;
        end else if (osc_tick) begin
            acc_q <= hund_tick ? 16'(acc_sum - `RTC_HUND_WRAP) : acc_sum;
            div_q <= div_q + 15'h0001;
        end
    end

    // ----------------------------------------
    // running clock counters
    // ----------------------------------------
    logic [7:0] live_q [0:7];
    logic [7:0] live_d [0:7];
    logic [8:0] inc_w  [0:7];
    logic [7:0] step_w;

    assign inc_w[0] = bcd_inc(live_q[0], `RTC_HUND_TOP, `RTC_BCD_ZERO);
    assign inc_w[1] = bcd_inc(live_q[1], `RTC_SEC_TOP, `RTC_BCD_ZERO);
    assign inc_w[2] = bcd_inc(live_q[2], `RTC_SEC_TOP, `RTC_BCD_ZERO);
    assign inc_w[3] = bcd_inc({2'h0, live_q[3][5:0]}, `RTC_HOUR_TOP,
                              `RTC_BCD_ZERO);
    assign inc_w[4] = bcd_inc(live_q[4], `RTC_WDAY_TOP, `RTC_BCD_ONE);
    assign inc_w[5] = bcd_inc(live_q[5], month_len(live_q[6], live_q[7]),
                              `RTC_BCD_ONE);
    assign inc_w[6] = bcd_inc(live_q[6], `RTC_MONTH_TOP, `RTC_BCD_ONE);
    assign inc_w[7] = bcd_inc(live_q[7], `RTC_YEAR_TOP, `RTC_BCD_ZERO);

    // carry chain: hundredths, seconds, minutes, hours, day, month, year
    assign step_w[0] = hund_tick;
    assign step_w[1] = step_w[0] && inc_w[0][8];
    assign step_w[2] = step_w[1] && inc_w[1][8];
    assign step_w[3] = step_w[2] && inc_w[2][8];
    assign step_w[4] = step_w[3] && inc_w[3][8];
    assign step_w[5] = step_w[4] && inc_w[5][8];
    assign step_w[6] = step_w[5] && inc_w[6][8];
    assign step_w[7] = step_w[6] && inc_w[7][8];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            live_d[i] = live_q[i];
        end
        if (step_w[0]) live_d[0] = inc_w[0][7:0];
        if (step_w[1]) live_d[1] = inc_w[1][7:0];
        if (step_w[2]) live_d[2] = inc_w[2][7:0];
        if (step_w[3]) live_d[3][5:0] = inc_w[3][5:0];
        if (step_w[7]) live_d[3][7:6] = 2'(live_q[3][7:6] + 2'h1);
        if (step_w[4]) live_d[4] = inc_w[4][7:0];
        if (step_w[4]) live_d[5] = inc_w[5][7:0];
        if (step_w[5]) live_d[6] = inc_w[6][7:0];
        if (step_w[6]) live_d[7] = inc_w[7][7:0];
        // a host write overrides a carry landing in the same cycle
        if (wr_clock) live_d[wr_addr[2:0]] = wr_data;
    end

    // keeps counting on battery, so no power state gates it
    always_ff @(posedge i_clock) begin
        for (int i = 0; i < 8; i++) begin
            if (!i_rst_b) begin
                live_q[i] <= (i >= 4) ? `RTC_BCD_ONE : `RTC_BCD_ZERO;
            end else begin
                live_q[i] <= live_d[i];
            end
        end
    end

    // ----------------------------------------
    // alarm match
    // ----------------------------------------
    logic match_q;

    wire alarm_en = mem_q[`RTC_ADDR_ALM_CTL][`RTC_BIT_ALM_EN];
    wire match_w  = alarm_en
                 && (live_q[1] == mem_q[`RTC_ADDR_ALM_SEC])
                 && (live_q[2] == mem_q[`RTC_ADDR_ALM_MIN])
                 && (live_q[3][5:0] == mem_q[`RTC_ADDR_ALM_HR][5:0]);
    wire alarm_event = match_w && !match_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_w;
        end
    end

    // ----------------------------------------
    // register map
    // ----------------------------------------
    // bytes 00-07 are the user copy of the counters, the rest is storage
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= 8'h00;
            end
            mem_q[`RTC_ADDR_SQW] <= `RTC_SQW_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!freeze_w) mem_q[i] <= live_q[i];
            end
            if (wr_map) mem_q[wr_addr] <= wr_data;
            // the flag set wins over a host write in the same cycle
            if (alarm_event) mem_q[`RTC_ADDR_FLAGS][`RTC_BIT_ALM_FLAG] <= 1'b1;
        end
    end

    // ----------------------------------------
    // pin outputs
    // ----------------------------------------
    wire [3:0] sqw_code = mem_q[`RTC_ADDR_SQW][7:4];
    wire       ft_on    = mem_q[`RTC_ADDR_CTL][`RTC_BIT_FT];
    wire       out_bit  = mem_q[`RTC_ADDR_CTL][`RTC_BIT_OUT];
    wire       irq_on   = alarm_en
                       && mem_q[`RTC_ADDR_FLAGS][`RTC_BIT_ALM_FLAG];

    // code 1 is the oscillator itself, higher codes halve it each step
    wire sqw_d = (sqw_code == 4'h0) ? 1'b0 :
                 (sqw_code == 4'h1) ? xtal_sync_q[1] :
                 div_q[4'(sqw_code - 4'h2)];

    // test frequency first, then the interrupt, else the output bit
    wire pin_oe_d = ft_on  ? !div_q[`RTC_FT_TAP] :
                    irq_on ? 1'b1 : !out_bit;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_crystal_output           <= 1'b1;
            o_square_wave_pin          <= 1'b0;
            o_shared_interrupt_test_oe <= 1'b0;
            o_reset_oe                 <= 1'b1;
            o_battery_select           <= 1'b0;
        end else begin
            o_crystal_output           <= !xtal_sync_q[1];
            o_square_wave_pin          <= sqw_d;
            o_shared_interrupt_test_oe <= pin_oe_d;
            o_reset_oe                 <= (state_d != PS_RUN);
            o_battery_select           <= (state_d == PS_BACKUP);
        end
    end

    // open-drain pins only ever pull low
    assign o_shared_interrupt_test_pin = 1'b0;
    assign o_reset_pin                 = 1'b0;

endmodule // spi_rtc_calendar_core

// ==== rtl/rtc_map.svh ====
// register offsets, field positions, reset values and timing counts of the rtc core
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define RTC_CLOCK_BYTES   6'h08
`define RTC_ADDR_CTL      5'h08
`define RTC_ADDR_ALM_CTL  5'h0a
`define RTC_ADDR_ALM_HR   5'h0c
`define RTC_ADDR_ALM_MIN  5'h0d
`define RTC_ADDR_ALM_SEC  5'h0e
`define RTC_ADDR_FLAGS    5'h0f
`define RTC_ADDR_SQW      5'h13
`define RTC_BIT_OUT       7
`define RTC_BIT_FT        6
`define RTC_BIT_ALM_EN    7
`define RTC_BIT_ALM_FLAG  6
`define RTC_SQW_RESET     8'h10
`define RTC_FT_TAP        5

`define RTC_BCD_ZERO      8'h00
`define RTC_BCD_ONE       8'h01
`define RTC_HUND_TOP      8'h99
`define RTC_SEC_TOP       8'h59
`define RTC_HOUR_TOP      8'h23
`define RTC_WDAY_TOP      8'h07
`define RTC_MONTH_TOP     8'h12
`define RTC_YEAR_TOP      8'h99

`define RTC_OSC_HZ        32768
`define RTC_HUND_STEP     16'h0064
`define RTC_HUND_WRAP     16'h8000
`define RTC_CLOCK_MHZ     40
`define RTC_REC_TIME_US   100
`define RTC_REC_CYCLES    (`RTC_REC_TIME_US * `RTC_CLOCK_MHZ)

`endif

// ==== rtl/rtc_pkg.sv ====
// types shared by the rtc core and its serial link
package rtc_pkg;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } wr_word_t;

    typedef enum logic [1:0] {
        PS_RESET   = 2'b00,
        PS_RECOVER = 2'b01,
        PS_RUN     = 2'b11,
        PS_BACKUP  = 2'b10
    } pwr_state_t;

endpackage

// ==== rtl/spi_link.sv ====
// serial slave logic clocked by the host's serial clock
`timescale 1ns/1ps
`include "rtc_map.svh"
module spi_link (
    input  wire logic             i_spi_clock,
    input  wire logic             i_rst_b,
    input  wire logic             i_chip_enable_b,
    input  wire logic             i_serial_in_pin,
    input  wire logic [7:0]       i_read_byte,
    output logic      [5:0]       o_pointer,
    output logic                  o_freeze,
    output rtc_pkg::wr_word_t     o_wr_word,
    output logic                  o_wr_toggle,
    output logic                  o_serial_out_pin,
    output logic                  o_serial_out_oe
);
    import rtc_pkg::*;

    logic [2:0] bit_q;
    logic       hdr_q;
    logic       write_q;
    logic [5:0] ptr_q;
    logic [6:0] shift_q;
    logic [7:0] out_q;
    wr_word_t   word_q;
    logic       tog_q;

    wire [7:0] next_byte = {shift_q, i_serial_in_pin};
    wire       byte_done = (bit_q == 3'h7);
    wire       load_w    = hdr_q && !write_q && (bit_q == 3'h0);

    // ----------------------------------------
    // header and pointer, cleared by deselect
    // ----------------------------------------
    always_ff @(posedge i_spi_clock or posedge i_chip_enable_b) begin
        if (i_chip_enable_b) begin
            bit_q   <= 3'h0;
            hdr_q   <= 1'b0;
            write_q <= 1'b0;
            ptr_q   <= 6'h00;
            shift_q <= 7'h00;
        end else begin
            shift_q <= next_byte[6:0];
            bit_q   <= bit_q + 3'h1;
            if (byte_done && !hdr_q) begin
                hdr_q   <= 1'b1;
                write_q <= next_byte[7];
                ptr_q   <= next_byte[5:0];
            end else if (byte_done) begin
                ptr_q <= ptr_q + 6'h01;
            end
        end
    end

    // toggle must survive deselect, so only the core reset clears it
    always_ff @(posedge i_spi_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tog_q  <= 1'b0;
            word_q <= '0;
        end else if (!i_chip_enable_b && byte_done && hdr_q && write_q) begin
            word_q <= '{addr: ptr_q, data: next_byte};
            tog_q  <= ~tog_q;
        end
    end

    // ----------------------------------------
    // read shifter, changes on falling edge
    // ----------------------------------------
    always_ff @(negedge i_spi_clock or posedge i_chip_enable_b) begin
        if (i_chip_enable_b) begin
            out_q <= 8'h00;
        end else if (load_w) begin
            out_q <= i_read_byte;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign o_pointer        = ptr_q;
    assign o_wr_word        = word_q;
    assign o_wr_toggle      = tog_q;
    assign o_serial_out_pin = out_q[7];
    assign o_serial_out_oe  = !i_chip_enable_b && hdr_q && !write_q;
    // freeze until the pointer is known to lie outside the clock bytes
    assign o_freeze = !i_chip_enable_b
                    && (!hdr_q || ptr_q < `RTC_CLOCK_BYTES);

endmodule // spi_link

// ==== verification/rtc_core_monitor.sv ====
// port-level assertion checker for the rtc core
`timescale 1ns/1ps
module rtc_core_monitor (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_spi_clock,
    input wire logic i_chip_enable_b,
    input wire logic i_serial_in_pin,
    input wire logic i_crystal_input,
    input wire logic i_power_fail,
    input wire logic o_crystal_output,
    input wire logic o_serial_out_oe,
    input wire logic o_shared_interrupt_test_pin,
    input wire logic o_reset_pin,
    input wire logic o_reset_oe,
    input wire logic o_battery_select
);
    // ----
    // helper counters
    // ----
    logic [12:0] quiet_q;
    logic [3:0]  bit_q;
    logic        dir_q;

    // cycles of healthy power since reset or the last power fail, saturating
    always_ff @(posedge i_clock) begin
        if (!i_rst_b || i_power_fail) quiet_q <= '0;
        else if (quiet_q != 13'h1fff) quiet_q <= quiet_q + 13'h1;
    end
    always_ff @(posedge i_spi_clock or posedge i_chip_enable_b) begin
        if (i_chip_enable_b) bit_q <= '0;
        else if (bit_q != 4'hf) bit_q <= bit_q + 4'h1;
    end
    always_ff @(posedge i_spi_clock or posedge i_chip_enable_b) begin
        if (i_chip_enable_b) dir_q <= 1'b0;
        else if (bit_q == 4'h0) dir_q <= i_serial_in_pin;
    end

    // ----
    // properties
    // ----
    property p_rec_hold;
        @(posedge i_clock) disable iff (!i_rst_b) $rose(i_rst_b) |-> o_reset_oe [*8];
    endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("reset output dropped early");
    property p_rec_time;
        @(posedge i_clock) disable iff (!i_rst_b)
            $fell(o_reset_oe) |-> quiet_q >= 13'h0f9b && quiet_q <= 13'h0faa;
    endproperty
    a_rec_time: assert property (p_rec_time) else $error("recovery time wrong");
    property p_pf_reset;
        @(posedge i_clock) disable iff (!i_rst_b) i_power_fail [*5] |-> o_reset_oe;
    endproperty
    a_pf_reset: assert property (p_pf_reset) else $error("no reset in power fail");
    property p_pf_batt;
        @(posedge i_clock) disable iff (!i_rst_b)
            $rose(i_power_fail) && !o_reset_oe |-> ##[1:5] o_battery_select;
    endproperty
    a_pf_batt: assert property (p_pf_batt) else $error("no battery switch");
    property p_main_batt;
        @(posedge i_clock) disable iff (!i_rst_b) !i_power_fail [*5] |-> !o_battery_select;
    endproperty
    a_main_batt: assert property (p_main_batt) else $error("battery on main power");
    property p_open_drain;
        @(posedge i_clock) disable iff (!i_rst_b)
            o_shared_interrupt_test_pin == 1'b0 && o_reset_pin == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pin high");
    property p_xtal;
        @(posedge i_clock) disable iff (!i_rst_b) $rose(i_crystal_input) |-> ##[1:4] !o_crystal_output;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal output stuck");
    property p_deselect;
        @(posedge i_clock) disable iff (!i_rst_b) i_chip_enable_b |-> !o_serial_out_oe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("sdo driven deselected");
    property p_hdr_quiet;
        @(posedge i_spi_clock) disable iff (!i_rst_b || i_chip_enable_b)
            bit_q < 4'h8 |-> !o_serial_out_oe;
    endproperty
    a_hdr_quiet: assert property (p_hdr_quiet) else $error("sdo driven in header");
    property p_read_drive;
        @(posedge i_spi_clock) disable iff (!i_rst_b || i_chip_enable_b)
            bit_q >= 4'h8 && !dir_q |-> o_serial_out_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("sdo idle in read");
    property p_write_quiet;
        @(posedge i_spi_clock) disable iff (!i_rst_b || i_chip_enable_b) dir_q |-> !o_serial_out_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("sdo driven in write");
endmodule // rtc_core_monitor

bind spi_rtc_calendar_core rtc_core_monitor rtc_core_monitor_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_spi_clock(i_spi_clock),
    .i_chip_enable_b(i_chip_enable_b), .i_serial_in_pin(i_serial_in_pin),
    .i_crystal_input(i_crystal_input), .i_power_fail(i_power_fail),
    .o_crystal_output(o_crystal_output), .o_serial_out_oe(o_serial_out_oe),
    .o_shared_interrupt_test_pin(o_shared_interrupt_test_pin), .o_reset_pin(o_reset_pin),
    .o_reset_oe(o_reset_oe), .o_battery_select(o_battery_select));

// ==== verification/spi_host_model.sv ====
// serial host model, mode 0, clock idles low between frames
`timescale 1ns/1ps
module spi_host_model (
    output logic      o_spi_clock,
    output logic      o_chip_enable_b,
    output logic      o_serial_in_pin,
    input  wire logic i_serial_out_pin,
    input  wire logic i_serial_out_oe
);
    logic [7:0] data_q [0:7];

    initial begin
        o_spi_clock = 1'b0;
        o_chip_enable_b = 1'b1;
        o_serial_in_pin = 1'b0;
    end

    // sdo is only trusted while the device enables it
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_serial_in_pin = tx[i];
            #24 o_spi_clock = 1'b1;
            rx[i] = i_serial_out_oe ? i_serial_out_pin : 1'bx;
            #24 o_spi_clock = 1'b0;
        end
    endtask

    task automatic frame(input logic wr, input logic [6:0] addr, input int n);
        logic [7:0] rx;
        o_chip_enable_b = 1'b0;
        #24;
        shift_byte({wr, addr}, rx);
        for (int k = 0; k < n; k++) begin
            shift_byte(data_q[k], rx);
            if (!wr) data_q[k] = rx;
        end
        #24 o_chip_enable_b = 1'b1;
        // a deselected input carries junk, not the last bit
        o_serial_in_pin = ~o_serial_in_pin;
        #120;
    endtask
endmodule // spi_host_model

// ==== verification/spi_rtc_calendar_core_tb.sv ====
// self-checking bench for the rtc core
`timescale 1ns/1ps
module spi_rtc_calendar_core_tb;
    logic i_clock, i_rst_b, i_crystal_input, i_power_fail;
    logic spi_clock, chip_enable_b, serial_in, serial_out, serial_out_oe;
    logic square_wave, shared_oe, reset_oe, battery;
    int   n_fail, num_checks, cycles, xtal_cnt;

    spi_rtc_calendar_core spi_rtc_calendar_core_inst (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_spi_clock(spi_clock),
        .i_chip_enable_b(chip_enable_b), .i_serial_in_pin(serial_in),
        .i_crystal_input(i_crystal_input), .i_power_fail(i_power_fail), .o_crystal_output(),
        .o_serial_out_pin(serial_out), .o_serial_out_oe(serial_out_oe),
        .o_square_wave_pin(square_wave), .o_shared_interrupt_test_pin(),
        .o_shared_interrupt_test_oe(shared_oe), .o_reset_pin(), .o_reset_oe(reset_oe),
        .o_battery_select(battery));
    spi_host_model spi_host_model_inst (
        .o_spi_clock(spi_clock), .o_chip_enable_b(chip_enable_b), .o_serial_in_pin(serial_in),
        .i_serial_out_pin(serial_out), .i_serial_out_oe(serial_out_oe));

    // ----
    // clock, crystal, timeout
    // ----
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    // crystal far faster than real so a hundredth passes in about 3300 cycles
    always @(posedge i_clock) begin
        xtal_cnt <= (xtal_cnt == 4) ? 0 : xtal_cnt + 1;
        if (xtal_cnt == 4) i_crystal_input <= ~i_crystal_input;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            close_out();
        end
    end

    // ----
    // shared tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic send(input logic [6:0] a, input logic [63:0] v, input int n);
        for (int k = 0; k < n; k++) spi_host_model_inst.data_q[k] = v[63-8*k -: 8];
        spi_host_model_inst.frame(1'b1, a, n);
    endtask
    task automatic fetch(input logic [6:0] a, input int n, output logic [63:0] v);
        v = '0;
        spi_host_model_inst.frame(1'b0, a, n);
        for (int k = 0; k < n; k++) v[63-8*k -: 8] = spi_host_model_inst.data_q[k];
    endtask
    task automatic cmp(input logic [63:0] v, input logic [63:0] e, input int n, input string w);
        for (int k = 0; k < n; k++) check(v[63-8*k -: 8], e[63-8*k -: 8], w);
    endtask
    task automatic toggles(input int n, input bit sel, output int t);
        logic last;
        t = 0;
        last = sel ? shared_oe : square_wave;
        repeat (n) begin
            @(negedge i_clock);
            t += ((sel ? shared_oe : square_wave) !== last);
            last = sel ? shared_oe : square_wave;
        end
    endtask

    // ----
    // scenarios
    // ----
    task automatic s_reset();
        int n;
        check({7'h0, reset_oe}, 8'h01, "reset out in reset");
        check({7'h0, battery}, 8'h00, "battery in reset");
        @(posedge i_clock) i_rst_b <= 1'b1;
        n = 0;
        while (reset_oe === 1'b1 && n < 4100) begin
            @(negedge i_clock);
            n++;
        end
        check({7'h0, n >= 3995 && n <= 4010}, 8'h01, "recovery time");
    endtask
    task automatic s_defaults();
        logic [63:0] d;
        int t;
        check({7'h0, shared_oe}, 8'h01, "output bit default");
        fetch(7'h13, 1, d);
        check(d[63:56], 8'h10, "square wave code");
        toggles(200, 1'b0, t);
        check(t[7:0], 8'h28, "square wave rate");
    endtask
    task automatic s_ram();
        logic [63:0] d;
        send(7'h19, 64'h0123456789abcdef, 7);
        fetch(7'h19, 7, d);
        cmp(d, 64'h0123456789abcd00, 7, "user bytes");
    endtask
    task automatic s_wrap();
        logic [63:0] d;
        send(7'h3f, 64'hc300450000000000, 3);
        fetch(7'h1f, 1, d);
        check(d[63:56], 8'hc3, "byte before wrap");
        fetch(7'h01, 1, d);
        check(d[63:56], 8'h45, "byte after wrap");
    endtask
    // hundredths written last so a tick mid-burst cannot spoil the start time
    task automatic s_cal(input logic [7:0] yr, input logic [23:0] exp);
        logic [63:0] d;
        send(7'h01, {48'h595923072802, yr, 8'h00}, 7);
        send(7'h00, 64'h9900000000000000, 1);
        idle(4000);
        fetch(7'h04, 3, d);
        cmp(d, {exp, 40'h0}, 3, "calendar rollover");
    endtask
    task automatic s_shared();
        int t;
        send(7'h08, 64'h8000000000000000, 1);
        idle(8);
        check({7'h0, shared_oe}, 8'h00, "output bit high");
        send(7'h08, 64'h4000000000000000, 1);
        toggles(1400, 1'b1, t);
        check({7'h0, t >= 4 && t <= 5}, 8'h01, "frequency test rate");
        send(7'h08, 64'h0, 1);
        idle(8);
        check({7'h0, shared_oe}, 8'h01, "output bit low");
    endtask
    task automatic s_power();
        logic [63:0] d;
        @(posedge i_clock) i_power_fail <= 1'b1;
        idle(8);
        check({7'h0, battery}, 8'h01, "battery on fail");
        check({7'h0, reset_oe}, 8'h01, "reset on fail");
        send(7'h1a, 64'hee00000000000000, 1);
        @(posedge i_clock) i_power_fail <= 1'b0;
        idle(4100);
        check({7'h0, reset_oe}, 8'h00, "reset after return");
        check({7'h0, battery}, 8'h00, "main after return");
        fetch(7'h1a, 1, d);
        check(d[63:56], 8'h23, "write in fail refused");
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        xtal_cnt = 0;
        i_rst_b = 1'b0;
        i_crystal_input = 1'b0;
        i_power_fail = 1'b0;
        idle(4);
        s_reset();
        s_defaults();
        s_ram();
        s_wrap();
        s_cal(8'h01, 24'h010103);
        s_cal(8'h04, 24'h012902);
        s_shared();
        s_power();
        close_out();
    end
endmodule // spi_rtc_calendar_core_tb
